// ### rtl/atrs_pkg.sv
// What this block does
// - Changing the timer clock source may corrupt count, compare and control contents.
// - In asynchronous mode, count, compare and control writes go to a holding register, loaded after two slow clock rising edges.
// - Count, compare and control each own an independent holding register.
// - Compare matching is suppressed while a count or compare write is pending.
// - Wake logic needs one slow cycle to rearm after a wake-up.
// - In asynchronous mode the slow oscillator runs in every mode but power-down.
// - Timer register contents are not guaranteed after waking from power-down.
// - Wake-up starts on the slow clock cycle after the interrupt condition.
// - After a timer wake-up the processor stalls four cycles before the handler.
// - Interrupt flag reaches processor three processor cycles after the timer cycle.
// - Compare output pin changes on the slow timer tick, not resynchronised.
// - After power-save wake, count reads stay stale until the next slow edge.
// - Hardware never alters compare or control, so their reads are exact.
// - Clock select 0 picks the processor clock, 1 the slow crystal input.
// - Asynchronous writes set a pending flag, cleared when the destination loads.
// - Count reads give a copy of the count that freezes in power-save; compare and control read holding registers.
package atrs_pkg;

   typedef logic [2:0] atrs_addr_t;
   typedef logic [7:0] atrs_byte_t;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam atrs_addr_t REG_COUNT   = 3'h0;
   localparam atrs_addr_t REG_COMPARE = 3'h1;
   localparam atrs_addr_t REG_CONTROL = 3'h2;
   localparam atrs_addr_t REG_STATUS  = 3'h3;
   localparam atrs_addr_t REG_IRQ     = 3'h4;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int ST_CONTROL_PEND = 0;
   localparam int ST_COMPARE_PEND = 1;
   localparam int ST_COUNT_PEND   = 2;
   localparam int ST_CLOCK_SEL    = 3;
   localparam int IRQ_CMP_EN      = 0;
   localparam int IRQ_OVF_EN      = 1;
   localparam int IRQ_CMP_FLAG    = 2;
   localparam int IRQ_OVF_FLAG    = 3;
   localparam int CTL_RUN         = 0;
   localparam int CTL_CLR_MATCH   = 1;
   localparam int CTL_OUT_LSB     = 2;

   localparam logic [1:0] OUT_NONE   = 2'h0;
   localparam logic [1:0] OUT_TOGGLE = 2'h1;
   localparam logic [1:0] OUT_CLEAR  = 2'h2;
   localparam logic [1:0] OUT_SET    = 2'h3;

   // ****************************************
   // Reset values and timing counts
   // ****************************************
   localparam atrs_byte_t RST_BYTE          = 8'h00;
   localparam atrs_byte_t COUNT_TOP         = 8'hFF;
   localparam logic [1:0] LOAD_EDGES        = 2'h2;
   localparam logic [2:0] WAKE_STALL_CYCLES = 3'h4;
   localparam int         FLAG_SYNC_CYCLES  = 3;

   typedef enum logic [1:0] {
      ATRS_ACTIVE,
      ATRS_IDLE,
      ATRS_POWER_SAVE,
      ATRS_POWER_DOWN
   } atrs_sleep_t;

   typedef struct packed {
      atrs_addr_t addr;
      atrs_byte_t wdata;
      logic       wr;
      logic       rd;
   } atrs_bus_t;

   typedef struct packed {
      logic       pending;
      logic [1:0] edges;
      atrs_byte_t value;
   } atrs_hold_t;

   typedef struct packed {
      atrs_hold_t                  count_h;
      atrs_hold_t                  compare_h;
      atrs_hold_t                  control_h;
      atrs_byte_t                  count;
      atrs_byte_t                  compare;
      atrs_byte_t                  control;
      atrs_byte_t                  count_view;
      atrs_byte_t                  rdata;
      logic                        clk_sel;
      logic                        cmp_en;
      logic                        ovf_en;
      logic                        cmp_flag;
      logic                        ovf_flag;
      logic [FLAG_SYNC_CYCLES-1:0] cmp_pipe;
      logic [FLAG_SYNC_CYCLES-1:0] ovf_pipe;
      logic                        pin_last;
      logic                        blank_next;
      logic                        cmp_pin;
      logic                        wake_armed;
      logic                        wake_req;
      logic                        wake;
      logic [2:0]                  stall_cnt;
   } atrs_state_t;

endpackage

// ### rtl/atrs_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module atrs_sync2 (
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   input  wire logic i_async,
   output logic      o_sync
);
   typedef struct packed {
      logic first;
      logic second;
   } atrs_sync_t;

   atrs_sync_t s;
   atrs_sync_t next_s;

   always_comb begin
      next_s.first  = i_async;
      next_s.second = s.first;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_sync = s.second;
endmodule // atrs_sync2
`default_nettype wire

// ### rtl/atrs_timer.sv
`timescale 1ns/1ps
`default_nettype none
module atrs_timer (
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire atrs_pkg::atrs_bus_t   i_bus,
   input  wire atrs_pkg::atrs_sleep_t i_sleep_mode,
   input  wire logic              i_slow_crystal_input,
   output logic [7:0]             o_rdata,
   output logic                   o_compare_pin,
   output logic                   o_compare_irq,
   output logic                   o_overflow_irq,
   output logic                   o_wake,
   output logic                   o_core_stall,
   output logic                   o_slow_osc_enable,
   output logic                   o_update_pending
);
   import atrs_pkg::*;

   atrs_state_t s;
   atrs_state_t next_s;
   logic        pin_sync;
   logic        osc_on;
   logic        slow_edge;
   logic        tick;
   logic        load_count;
   logic        load_compare;
   logic        load_control;
   logic        match;
   logic        overflow;
   logic        cmp_set;
   logic        ovf_set;
   logic        irq_cond;
   atrs_byte_t  read_mux;
   atrs_byte_t  count_next;

   // ****************************************
   // Slow crystal edge detection
   // ****************************************
   atrs_sync2 u_pin_sync (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_async    (i_slow_crystal_input),
      .o_sync     (pin_sync)
   );

   // Holding register transfer on the second slow edge after a write
   function automatic atrs_hold_t advance(input atrs_hold_t h, input logic edge_seen);
      atrs_hold_t r;
      r = h;
      if (h.pending && edge_seen) begin
         r.edges = 2'(h.edges + 2'h1);
         if (r.edges == LOAD_EDGES) begin
            r.pending = 1'b0;
         end
      end
      return r;
   endfunction

   always_comb begin
      next_s = s;
      next_s.wake     = 1'b0;
      next_s.pin_last = pin_sync;
      // Oscillator off in power-down and whenever the processor clock is selected
      osc_on    = s.clk_sel && (i_sleep_mode != ATRS_POWER_DOWN);
      slow_edge = osc_on && pin_sync && !s.pin_last;
      // Select 1 counts slow edges, 0 counts core cycles while the core runs
      if (s.clk_sel) begin
         tick = slow_edge;
      end else begin
         tick = (i_sleep_mode == ATRS_ACTIVE) || (i_sleep_mode == ATRS_IDLE);
      end

      // ****************************************
      // Holding register transfers
      // ****************************************
      next_s.count_h   = advance(s.count_h, slow_edge);
      next_s.compare_h = advance(s.compare_h, slow_edge);
      next_s.control_h = advance(s.control_h, slow_edge);
      load_count   = s.count_h.pending && !next_s.count_h.pending;
      load_compare = s.compare_h.pending && !next_s.compare_h.pending;
      load_control = s.control_h.pending && !next_s.control_h.pending;
      if (load_compare) begin
         next_s.compare = s.compare_h.value;
      end
      if (load_control) begin
         next_s.control = s.control_h.value;
      end

      // ****************************************
      // Counter, compare and overflow
      // ****************************************
      match = tick && s.control[CTL_RUN] && (s.count == s.compare)
            && !s.count_h.pending && !s.compare_h.pending && !s.blank_next;
      overflow   = tick && s.control[CTL_RUN] && (s.count == COUNT_TOP);
      count_next = s.count;
      if (load_count) begin
         count_next = s.count_h.value;
      end else if (match && s.control[CTL_CLR_MATCH]) begin
         count_next = RST_BYTE;
      end else if (tick && s.control[CTL_RUN]) begin
         count_next = 8'(s.count + 8'h01);
      end
      next_s.count = count_next;
      if (tick) begin
         next_s.blank_next = 1'b0;
      end
      // Pin follows the timer tick directly
      if (match) begin
         case (s.control[CTL_OUT_LSB +: 2])
            OUT_TOGGLE: next_s.cmp_pin = !s.cmp_pin;
            OUT_CLEAR:  next_s.cmp_pin = 1'b0;
            OUT_SET:    next_s.cmp_pin = 1'b1;
            default:    next_s.cmp_pin = s.cmp_pin;
         endcase
      end
      // Core view of the count freezes during power-save
      if (!s.clk_sel) begin
         next_s.count_view = count_next;
      end else if (slow_edge && i_sleep_mode != ATRS_POWER_SAVE) begin
         next_s.count_view = count_next;
      end

      // ****************************************
      // Interrupt flag synchronisation
      // ****************************************
      next_s.cmp_pipe = {s.cmp_pipe[FLAG_SYNC_CYCLES-2:0], match && s.clk_sel};
      next_s.ovf_pipe = {s.ovf_pipe[FLAG_SYNC_CYCLES-2:0], overflow && s.clk_sel};
      cmp_set = s.clk_sel ? s.cmp_pipe[FLAG_SYNC_CYCLES-1] : match;
      ovf_set = s.clk_sel ? s.ovf_pipe[FLAG_SYNC_CYCLES-1] : overflow;
      next_s.cmp_flag = s.cmp_flag;
      next_s.ovf_flag = s.ovf_flag;
      if (i_bus.wr && i_bus.addr == REG_IRQ) begin
         next_s.cmp_en = i_bus.wdata[IRQ_CMP_EN];
         next_s.ovf_en = i_bus.wdata[IRQ_OVF_EN];
         if (i_bus.wdata[IRQ_CMP_FLAG]) begin
            next_s.cmp_flag = 1'b0;
         end
         if (i_bus.wdata[IRQ_OVF_FLAG]) begin
            next_s.ovf_flag = 1'b0;
         end
      end
      // Set wins over a same-cycle clear
      if (cmp_set) begin
         next_s.cmp_flag = 1'b1;
      end
      if (ovf_set) begin
         next_s.ovf_flag = 1'b1;
      end

      // ****************************************
      // Power-save wake-up
      // ****************************************
      irq_cond = (s.cmp_flag && s.cmp_en) || (s.ovf_flag && s.ovf_en);
      if (i_sleep_mode == ATRS_POWER_SAVE && s.wake_armed && irq_cond) begin
         next_s.wake_req = 1'b1;
      end
      if (s.wake_req && slow_edge) begin
         next_s.wake       = 1'b1;
         next_s.wake_req   = 1'b0;
         next_s.wake_armed = 1'b0;
      end else if (!s.wake_armed && slow_edge) begin
         next_s.wake_armed = 1'b1;
      end
      if (!s.clk_sel) begin
         next_s.wake_req   = 1'b0;
         next_s.wake_armed = 1'b1;
      end
      // Stall starts the cycle after the wake pulse and lasts four cycles
      if (s.wake) begin
         next_s.stall_cnt = WAKE_STALL_CYCLES;
      end else if (s.stall_cnt != 3'h0) begin
         next_s.stall_cnt = 3'(s.stall_cnt - 3'h1);
      end
      // Oscillator stopped: transfers are dropped, contents not trusted
      if (i_sleep_mode == ATRS_POWER_DOWN) begin
         next_s.count_h.pending   = 1'b0;
         next_s.compare_h.pending = 1'b0;
         next_s.control_h.pending = 1'b0;
         next_s.wake_req          = 1'b0;
      end

      // ****************************************
      // Register writes
      // ****************************************
      if (i_bus.wr) begin
         case (i_bus.addr)
            REG_COUNT: begin
               next_s.count_h.value = i_bus.wdata;
               if (s.clk_sel) begin
                  next_s.count_h.pending = 1'b1;
                  next_s.count_h.edges   = 2'h0;
               end else begin
                  next_s.count      = i_bus.wdata;
                  next_s.count_view = i_bus.wdata;
                  next_s.blank_next = 1'b1;
               end
            end
            REG_COMPARE: begin
               next_s.compare_h.value = i_bus.wdata;
               if (s.clk_sel) begin
                  next_s.compare_h.pending = 1'b1;
                  next_s.compare_h.edges   = 2'h0;
               end else begin
                  next_s.compare = i_bus.wdata;
               end
            end
            REG_CONTROL: begin
               next_s.control_h.value = i_bus.wdata;
               if (s.clk_sel) begin
                  next_s.control_h.pending = 1'b1;
                  next_s.control_h.edges   = 2'h0;
               end else begin
                  next_s.control = i_bus.wdata;
               end
            end
            REG_STATUS: begin
               next_s.clk_sel = i_bus.wdata[ST_CLOCK_SEL];
               // Source change abandons transfers in flight
               if (i_bus.wdata[ST_CLOCK_SEL] != s.clk_sel) begin
                  next_s.count_h.pending   = 1'b0;
                  next_s.compare_h.pending = 1'b0;
                  next_s.control_h.pending = 1'b0;
                  next_s.cmp_pipe          = '0;
                  next_s.ovf_pipe          = '0;
               end
            end
            default: begin
            end
         endcase
      end

      // ****************************************
      // Register reads
      // ****************************************
      case (i_bus.addr)
         REG_COUNT:   read_mux = s.count_view;
         REG_COMPARE: read_mux = s.compare_h.value;
         REG_CONTROL: read_mux = s.control_h.value;
         REG_STATUS:  read_mux = {4'h0, s.clk_sel, s.count_h.pending,
                                  s.compare_h.pending, s.control_h.pending};
         REG_IRQ:     read_mux = {4'h0, s.ovf_flag, s.cmp_flag, s.ovf_en, s.cmp_en};
         default:     read_mux = RST_BYTE;
      endcase
      next_s.rdata = i_bus.rd ? read_mux : RST_BYTE;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         s <= '0;
         s.wake_armed <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign o_rdata           = s.rdata;
   assign o_compare_pin     = s.cmp_pin;
   assign o_compare_irq     = s.cmp_flag && s.cmp_en;
   assign o_overflow_irq    = s.ovf_flag && s.ovf_en;
   assign o_wake            = s.wake;
   assign o_core_stall      = (s.stall_cnt != 3'h0);
   assign o_slow_osc_enable = osc_on;
   assign o_update_pending  = s.count_h.pending || s.compare_h.pending
                            || s.control_h.pending;
endmodule // atrs_timer
`default_nettype wire

// ### testbench/atrs_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module atrs_timer_properties (
   input wire logic                  i_core_clk,
   input wire logic                  i_reset,
   input wire atrs_pkg::atrs_bus_t   i_bus,
   input wire atrs_pkg::atrs_sleep_t i_sleep_mode,
   input wire logic                  i_slow_crystal_input,
   input wire logic [7:0]            o_rdata,
   input wire logic                  o_compare_pin,
   input wire logic                  o_compare_irq,
   input wire logic                  o_wake,
   input wire logic                  o_core_stall,
   input wire logic                  o_slow_osc_enable,
   input wire logic                  o_update_pending
);
   import atrs_pkg::*;
   logic       sel;
   logic       cmp_en;
   logic       xtal_q;
   logic [3:0] age;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   // ****************************************
   // Mirror of select, enable and crystal age
   // ****************************************
   always_ff @(posedge i_core_clk) begin
      xtal_q <= i_slow_crystal_input;
      if (i_reset) begin
         sel    <= 1'b0;
         cmp_en <= 1'b0;
         age    <= 4'hF;
      end else begin
         if (i_bus.wr && i_bus.addr == REG_STATUS) sel <= i_bus.wdata[ST_CLOCK_SEL];
         if (i_bus.wr && i_bus.addr == REG_IRQ) cmp_en <= i_bus.wdata[IRQ_CMP_EN];
         age <= (i_slow_crystal_input && !xtal_q) ? 4'h0 : ((age == 4'hF) ? age : age + 4'h1);
      end
   end
   sequence stall_run;
      o_core_stall [*4] ##1 !o_core_stall;
   endsequence
   // ****************************************
   // Properties
   // ****************************************
   chk_rdata_quiet: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
      else $error("read data outside the read answer cycle");
   chk_pend_set: assert property (i_bus.wr && sel && i_bus.addr <= REG_CONTROL
      && i_sleep_mode != ATRS_POWER_DOWN |=> o_update_pending)
      else $error("async write did not raise pending");
   chk_sync_load: assert property (i_bus.wr && !sel && !o_update_pending
      |=> !o_update_pending)
      else $error("sync write raised pending");
   chk_hold_two_edges: assert property ($rose(o_update_pending)
      |-> o_update_pending [*8])
      else $error("holding register loaded too early");
   chk_pend_bound: assert property (o_update_pending |-> ##[1:40] !o_update_pending)
      else $error("pending transfer never completed");
   chk_wake_pulse: assert property (o_wake |=> !o_wake)
      else $error("wake pulse longer than one cycle");
   chk_wake_stall: assert property (o_wake |=> stall_run)
      else $error("stall after wake not four cycles");
   chk_stall_cause: assert property ($rose(o_core_stall) |-> $past(o_wake))
      else $error("stall without wake");
   chk_osc_down: assert property (i_sleep_mode == ATRS_POWER_DOWN |-> !o_slow_osc_enable)
      else $error("oscillator running in power-down");
   chk_osc_select: assert property (o_slow_osc_enable
      == (sel && i_sleep_mode != ATRS_POWER_DOWN))
      else $error("oscillator enable does not follow select");
   chk_irq_mask: assert property (!cmp_en |-> !o_compare_irq)
      else $error("compare irq while disabled");
   chk_pin_tick: assert property (sel && $past(sel) && $changed(o_compare_pin)
      |-> age < 4'h8)
      else $error("compare pin moved away from a slow tick");
endmodule // atrs_timer_properties
bind atrs_timer atrs_timer_properties i_atrs_timer_properties (.i_core_clk, .i_reset,
   .i_bus, .i_sleep_mode, .i_slow_crystal_input, .o_rdata, .o_compare_pin,
   .o_compare_irq, .o_wake, .o_core_stall, .o_slow_osc_enable, .o_update_pending);
`default_nettype wire

// ### testbench/atrs_crystal.sv
`timescale 1ns/1ps
`default_nettype none
module atrs_crystal #(
   parameter int HALF_NS = 53
) (
   input  wire logic i_enable,
   output logic      o_clk
);
   // Watch crystal stand-in, far below a quarter of the core rate
   initial o_clk = 1'b0;
   always begin
      #(HALF_NS);
      o_clk = i_enable ? ~o_clk : 1'b0; // Stands low while disabled
   end
endmodule // atrs_crystal
`default_nettype wire

// ### testbench/test_async_timer_register_sync.sv
`timescale 1ns/1ps
`default_nettype none
module test_async_timer_register_sync;
   import atrs_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   atrs_bus_t   bus = '0;
   atrs_sleep_t mode = ATRS_ACTIVE;
   logic        xtal;
   logic [7:0]  rdata;
   logic        pin, cirq, oirq, wake, stall, osc_en, pend, pin0;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          n;
   atrs_byte_t  v, c;
   atrs_byte_t  last_rd;
   atrs_addr_t  a;
   always #5 clk = ~clk;
   atrs_timer i_atrs_timer (.i_core_clk(clk), .i_reset(rst), .i_bus(bus),
      .i_sleep_mode(mode), .i_slow_crystal_input(xtal), .o_rdata(rdata),
      .o_compare_pin(pin), .o_compare_irq(cirq), .o_overflow_irq(oirq), .o_wake(wake),
      .o_core_stall(stall), .o_slow_osc_enable(osc_en), .o_update_pending(pend));
   atrs_crystal i_atrs_crystal (.i_enable(osc_en), .o_clk(xtal));
   // ****************************************
   // Bus tasks and checks
   // ****************************************
   function automatic atrs_byte_t status_exp(input logic s, input logic [2:0] p);
      return {4'h0, s, p};
   endfunction
   // Sync count with clear on match: period top + 1 core cycles from zero
   function automatic atrs_byte_t count_exp(input int cyc, input atrs_byte_t top);
      return 8'(cyc % (int'(top) + 1));
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input atrs_addr_t ad, input atrs_byte_t d);
      bus.addr  <= ad;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_raw(input atrs_addr_t ad);
      bus.addr <= ad;
      bus.rd   <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      @(posedge clk);
      last_rd = rdata;
   endtask
   task automatic rd(input atrs_addr_t ad, input atrs_byte_t exp);
      rd_raw(ad);
      check(last_rd, exp);
   endtask
   task automatic wait_sig(ref logic s, input int lim);
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic wait_idle();
      n = 0;
      while (pend !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      check({7'h0, pend}, 8'h00);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #500000;
      n_mismatch++;
      finish_test();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      void'($urandom(32'hFA61));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({7'h0, osc_en}, 8'h00);
      rd(REG_STATUS, status_exp(1'b0, 3'h0));
      rd(REG_IRQ, 8'h00);
      v = 8'($urandom);
      wr(REG_COMPARE, v);
      rd(REG_STATUS, status_exp(1'b0, 3'h0));
      rd(REG_COMPARE, v);
      wr(3'h5, v);
      rd(3'h5, 8'h00);
      $display("test sync_and_reset done");
      wr(REG_IRQ, 8'h0C);
      wr(REG_STATUS, 8'h08);
      rd(REG_STATUS, status_exp(1'b1, 3'h0));
      check({7'h0, osc_en}, 8'h01);
      repeat (32) @(posedge clk); // Scaled-down start-up settling
      for (int i = 0; i < 6; i++) begin
         v = 8'($urandom);
         a = (i % 2 == 1) ? REG_CONTROL : REG_COMPARE;
         wr(a, v);
         rd(REG_STATUS, status_exp(1'b1, (i % 2 == 1) ? 3'h1 : 3'h2));
         rd(a, v);
         wait_idle();
         check({7'h0, n >= 6}, 8'h01);
      end
      $display("test async_holding done");
      c = 8'h08 + 8'($urandom % 80);
      wr(REG_IRQ, 8'h0D);
      wr(REG_CONTROL, 8'h05);
      wr(REG_COMPARE, c);
      wr(REG_COUNT, c - 8'h03);
      rd(REG_STATUS, status_exp(1'b1, 3'h7));
      pin0 = pin;
      wait_idle();
      wait_sig(cirq, 300);
      check({7'h0, cirq}, 8'h01);
      check({7'h0, pin}, {7'h0, ~pin0});
      check({7'h0, oirq}, 8'h00);
      rd(REG_IRQ, 8'h05);
      rd(REG_CONTROL, 8'h05);
      $display("test compare_match done");
      mode <= ATRS_POWER_SAVE;
      wait_sig(wake, 100);
      check({7'h0, wake}, 8'h01);
      @(posedge clk);
      check({7'h0, stall}, 8'h01);
      mode <= ATRS_ACTIVE;
      wr(REG_IRQ, 8'h05);
      rd(REG_IRQ, 8'h01);
      wait_idle();
      wr(REG_CONTROL, 8'h05);
      wait_idle();
      rd_raw(REG_COUNT);
      check({7'h0, (last_rd > c) && (last_rd < c + 8'h30)}, 8'h01);
      $display("test wake done");
      mode <= ATRS_POWER_DOWN;
      @(posedge clk);
      @(posedge clk);
      check({7'h0, osc_en}, 8'h00);
      mode <= ATRS_ACTIVE;
      wr(REG_STATUS, 8'h00);
      check({7'h0, osc_en}, 8'h00);
      $display("test power_down done");
      c = 8'h10 + 8'($urandom % 32);
      wr(REG_CONTROL, 8'h0F);
      wr(REG_COMPARE, c);
      wr(REG_COUNT, 8'h00);
      wr(REG_IRQ, 8'h0C);
      repeat (80) @(posedge clk);
      check({7'h0, pin}, 8'h01);
      rd(REG_IRQ, 8'h04);
      rd(REG_COUNT, count_exp(85, c));
      $display("test sync_compare done");
      finish_test();
   end
endmodule // test_async_timer_register_sync
`default_nettype wire
